// ==== rtl/sps_consts.svh ====
// Register addresses, status bit positions, reset values and widths of the SPI status block.
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH

// ==================================================================
// Register addresses
`define SPS_ADDR_STATUS 8'hea
`define SPS_ADDR_RXDATA 8'h9b
`define SPS_ADDR_TXDATA 8'h9a

// ==================================================================
// Status bit positions
`define SPS_BIT_BUSY 7
`define SPS_BIT_MULTIMASTER_ERROR_FLAG 6
`define SPS_BIT_RXOVF 5
`define SPS_BIT_RXIRQ 4
`define SPS_BIT_RXFULL 3
`define SPS_BIT_TXUF 2

// ==================================================================
// Reset values and sizes
`define SPS_STATUS_RESET 8'h00
`define SPS_DATA_RESET 8'h00
`define SPS_BYTE_BITS 8
`define SPS_SYNC_STAGES 2

`endif

// ==== rtl/sps_pkg.sv ====
// Types shared by the SPI status block.
package sps_pkg;

  // ==================================================================
  // Transfer phase
  typedef enum logic [1:0] {
    SPS_IDLE = 2'b00,
    SPS_XFER = 2'b01,
    SPS_HALT = 2'b10
  } sps_phase_e;

  // ==================================================================
  // Special function register access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sps_sfr_s;

  // ==================================================================
  // Configuration bits held elsewhere in the port
  typedef struct packed {
    logic master_mode;
    logic ss_input_enable;
    logic transfer_interrupt_mode;
    logic overflow_overwrite_enable;
    logic port_irq_enable;
  } sps_cfg_s;

  // ==================================================================
  // Core-domain state
  typedef struct packed {
    sps_phase_e phase;
    logic [7:0] rx_data;
    logic rx_new;
    logic receive_overflow_flag;
    logic receive_interrupt_flag;
    logic receive_buffer_full_flag;
    logic transmit_underflow_flag;
    logic multimaster_error_flag;
    logic busy;
    logic [7:0] tx_data;
    logic tx_full;
    logic [7:0] tx_word;
    logic ss_n;
    logic ss_oe;
    logic ser_oe;
    logic irq;
    logic [7:0] rd_data;
    logic tgl_seen;
  } sps_state_s;

endpackage

// ==== rtl/sps_sync.sv ====
// Two-stage synchroniser into the core clock domain.
`include "sps_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module sps_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // ==================================================================
  // Stages
  // The first stage feeds only the second one.
  logic [`SPS_SYNC_STAGES-1:0][WIDTH-1:0] stage;
  logic [`SPS_SYNC_STAGES-1:0][WIDTH-1:0] next_stage;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("sps_sync width must be at least one");
  end

  always_comb
  begin
    next_stage = {stage[0], d};
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      stage <= '0;
    else
      stage <= next_stage;
  end

  assign q = stage[`SPS_SYNC_STAGES-1];

endmodule

`default_nettype wire

// ==== rtl/sps_shift.sv ====
// Link-clock shifter: shifts bytes in and out while the frame is selected.
`include "sps_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module sps_shift #(
  parameter int WIDTH = `SPS_BYTE_BITS
) (
  input wire logic sclk,
  input wire logic link_rst_n,
  input wire logic frame_n,
  input wire logic ser_in,
  input wire logic [WIDTH-1:0] tx_word,
  output logic ser_out,
  output logic [WIDTH-1:0] rx_word,
  output logic done_tgl
);

  localparam int CW = $clog2(WIDTH);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [WIDTH-2:0] sh;
  } sps_bit_s;

  typedef struct packed {
    logic [WIDTH-1:0] rx;
    logic tgl;
  } sps_word_s;

  if (WIDTH < 3 || (1 << CW) != WIDTH)
  begin : g_bad_width
    $error("sps_shift width must be a power of two of at least four");
  end

  // ==================================================================
  // State
  // The bit counter is cleared by the frame itself, because the link clock
  // stops outside frames. The byte toggle survives frames so no byte is lost.
  sps_bit_s b;
  sps_bit_s next_b;
  sps_word_s w;
  sps_word_s next_w;
  logic clr;

  assign clr = frame_n | ~link_rst_n;

  always_comb
  begin
    next_b = b;
    next_w = w;
    next_b.sh = {b.sh[WIDTH-3:0], ser_in};
    if (b.cnt == CW'(WIDTH - 1))
    begin
      next_b.cnt = '0;
      next_w.rx = {b.sh, ser_in};
      next_w.tgl = ~w.tgl;
    end
    else
    begin
      next_b.cnt = b.cnt + 1'b1;
    end
  end

  always_ff @(posedge sclk or posedge clr)
  begin
    if (clr)
      b <= '0;
    else
      b <= next_b;
  end

  always_ff @(posedge sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
      w <= '0;
    else
      w <= next_w;
  end

  // ==================================================================
  // Outputs
  // The outgoing word is held still by the core while a byte is on the wire.
  assign ser_out = tx_word[CW'(WIDTH - 1) - b.cnt];
  assign rx_word = w.rx;
  assign done_tgl = w.tgl;

endmodule

`default_nettype wire

// ==== rtl/sps_top.sv ====
// SPI port status flags, receive and transmit data registers and transfer control.
//
// How it works
// RQ1 - Bit 7 busy while transferring, else idle.
// RQ2 - Slave select low during master transfer: error.
// RQ3 - Software write clears error flag; otherwise sticky. Here only a write with bit 6 at zero clears it.
// RQ4 - Unread receive data at byte end: overflow.
// RQ5 - Overflow with overwrite enabled replaces receive data.
// RQ6 - Overflow without overwrite keeps the old byte.
// RQ7 - Receive data read clears overflow flag.
// RQ8 - Receive flag set on new byte, read clears.
// RQ9 - Interrupt in mode zero when receive flag set.
// RQ10 - Mode zero unread data halts, deasserts select.
// RQ11 - Buffer full set when full, read clears.
// RQ12 - Transmit underflow set when nothing to send.
// RQ13 - Software keeps transfer interrupt mode at one.
`include "sps_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module sps_top (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic SCLK,
  input wire sps_pkg::sps_sfr_s SFR_REQ,
  output logic [7:0] SFR_RDATA,
  input wire sps_pkg::sps_cfg_s CFG,
  input wire logic SER_IN,
  output logic SER_OUT,
  output logic SER_OE,
  input wire logic SS_N_IN,
  output logic SS_N_OUT,
  output logic SS_N_OE,
  output logic PORT_IRQ
);

  // ==================================================================
  // Helpers
  function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] target);
    sfr_hit = (addr == target);
  endfunction

  function automatic logic [7:0] status_byte(input sps_pkg::sps_state_s st);
    logic [7:0] v;
    v = `SPS_STATUS_RESET;
    v[`SPS_BIT_BUSY] = st.busy;
    v[`SPS_BIT_MULTIMASTER_ERROR_FLAG] = st.multimaster_error_flag;
    v[`SPS_BIT_RXOVF] = st.receive_overflow_flag;
    v[`SPS_BIT_RXIRQ] = st.receive_interrupt_flag;
    v[`SPS_BIT_RXFULL] = st.receive_buffer_full_flag;
    v[`SPS_BIT_TXUF] = st.transmit_underflow_flag;
    return v;
  endfunction

  // ==================================================================
  // Link side
  sps_pkg::sps_state_s s;
  sps_pkg::sps_state_s next_s;
  logic frame_n;
  logic done_tgl;
  logic [7:0] rx_word;
  logic [1:0] synced;
  logic done_sync;
  logic ss_sync_n;

  // In master mode the frame follows our own select; otherwise the pin.
  assign frame_n = CFG.master_mode ? s.ss_n : SS_N_IN;

  sps_shift #(
    .WIDTH(`SPS_BYTE_BITS)
  ) u_shift (
    .sclk(SCLK),
    .link_rst_n(RESETN),
    .frame_n(frame_n),
    .ser_in(SER_IN),
    .tx_word(s.tx_word),
    .ser_out(SER_OUT),
    .rx_word(rx_word),
    .done_tgl(done_tgl)
  );

  sps_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(CLK),
    .resetn(RESETN),
    .d({done_tgl, ~SS_N_IN}),
    .q(synced)
  );

  assign done_sync = synced[1];
  // The select is inverted through the synchroniser so that its reset value reads as deselected.
  assign ss_sync_n = ~synced[0];

  // ==================================================================
  // Decode
  logic rd_status;
  logic rd_rx;
  logic wr_status;
  logic wr_tx;
  logic byte_done;
  logic rx_unread;

  assign rd_status = SFR_REQ.rd && sfr_hit(SFR_REQ.addr, `SPS_ADDR_STATUS);
  assign rd_rx = SFR_REQ.rd && sfr_hit(SFR_REQ.addr, `SPS_ADDR_RXDATA);
  assign wr_status = SFR_REQ.wr && sfr_hit(SFR_REQ.addr, `SPS_ADDR_STATUS);
  assign wr_tx = SFR_REQ.wr && sfr_hit(SFR_REQ.addr, `SPS_ADDR_TXDATA);
  assign byte_done = done_sync ^ s.tgl_seen;
  // A read in the very cycle a byte lands counts as read in time.
  assign rx_unread = s.rx_new && !rd_rx;

  // ==================================================================
  // Next state
  always_comb
  begin
    next_s = s;
    next_s.tgl_seen = done_sync;

    if (rd_status)
      next_s.rd_data = status_byte(s);
    else if (rd_rx)
      next_s.rd_data = s.rx_data;
    else if (SFR_REQ.rd)
      next_s.rd_data = `SPS_DATA_RESET;

    // Clears first, so that a hardware set in the same cycle wins.
    if (wr_status && !SFR_REQ.wdata[`SPS_BIT_MULTIMASTER_ERROR_FLAG])
      next_s.multimaster_error_flag = 1'b0; // [RQ3]
    if (rd_rx)
    begin
      next_s.rx_new = 1'b0;
      next_s.receive_overflow_flag = 1'b0; // [RQ7]
      next_s.receive_interrupt_flag = 1'b0; // [RQ8]
      next_s.receive_buffer_full_flag = 1'b0; // [RQ11]
    end
    if (wr_tx)
    begin
      next_s.tx_data = SFR_REQ.wdata;
      next_s.tx_full = 1'b1;
      next_s.transmit_underflow_flag = 1'b0;
    end

    case (s.phase)
      sps_pkg::SPS_IDLE:
      begin
        if (CFG.master_mode && next_s.tx_full)
        begin
          next_s.tx_word = next_s.tx_data;
          next_s.tx_full = 1'b0;
          next_s.ss_n = 1'b0;
          next_s.phase = sps_pkg::SPS_XFER;
        end
        else if (!CFG.master_mode && !ss_sync_n)
        begin
          next_s.phase = sps_pkg::SPS_XFER;
        end
      end
      sps_pkg::SPS_XFER:
      begin
        if (byte_done)
        begin
          if (rx_unread && !CFG.transfer_interrupt_mode)
          begin
            // The new byte is dropped and the select released.
            next_s.phase = sps_pkg::SPS_HALT; // [RQ10]
            next_s.ss_n = 1'b1; // [RQ10]
          end
          else
          begin
            if (rx_unread)
            begin
              next_s.receive_overflow_flag = 1'b1; // [RQ4]
              if (CFG.overflow_overwrite_enable)
                next_s.rx_data = rx_word; // [RQ5]
              // Without overwrite the earlier byte stays in place. [RQ6]
            end
            else
            begin
              next_s.rx_data = rx_word;
              next_s.rx_new = 1'b1;
            end
            next_s.receive_interrupt_flag = 1'b1; // [RQ8]
            next_s.receive_buffer_full_flag = 1'b1; // [RQ11]
            if (next_s.tx_full && !CFG.master_mode)
            begin
              next_s.tx_word = next_s.tx_data;
              next_s.tx_full = 1'b0;
            end
            else if (!next_s.tx_full)
            begin
              next_s.transmit_underflow_flag = 1'b1; // [RQ12]
            end
            if (CFG.master_mode)
            begin
              // One byte per select; the next byte starts after a gap.
              next_s.ss_n = 1'b1;
              next_s.phase = sps_pkg::SPS_IDLE;
            end
          end
        end
        else if (!CFG.master_mode && ss_sync_n)
        begin
          next_s.phase = sps_pkg::SPS_IDLE;
        end
      end
      sps_pkg::SPS_HALT:
      begin
        next_s.ss_n = 1'b1; // [RQ10]
        if (!next_s.rx_new && (CFG.master_mode || ss_sync_n))
          next_s.phase = sps_pkg::SPS_IDLE;
      end
      default:
      begin
        next_s.phase = sps_pkg::SPS_IDLE;
      end
    endcase

    if (CFG.master_mode && CFG.ss_input_enable && s.phase == sps_pkg::SPS_XFER && !ss_sync_n)
      next_s.multimaster_error_flag = 1'b1; // [RQ2]

    next_s.busy = (next_s.phase == sps_pkg::SPS_XFER); // [RQ1]
    next_s.ss_oe = CFG.master_mode && !CFG.ss_input_enable;
    next_s.ser_oe = CFG.master_mode || (next_s.phase == sps_pkg::SPS_XFER);
    next_s.irq = CFG.port_irq_enable && !CFG.transfer_interrupt_mode
                 && next_s.receive_interrupt_flag; // [RQ9]
  end

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      s <= '0;
      s.ss_n <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ==================================================================
  // Outputs
  assign SFR_RDATA = s.rd_data;
  assign SER_OE = s.ser_oe;
  assign SS_N_OUT = s.ss_n;
  assign SS_N_OE = s.ss_oe;
  assign PORT_IRQ = s.irq;

  // ==================================================================
  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  sequence seq_byte_lands;
    s.phase == sps_pkg::SPS_XFER && byte_done;
  endsequence

  sequence seq_unread_tim1;
    seq_byte_lands ##0 rx_unread && CFG.transfer_interrupt_mode;
  endsequence

  chk_busy_status: assert property ( // [RQ1]
    rd_status |=> SFR_RDATA[`SPS_BIT_BUSY] == $past(s.busy)
                  && s.busy == (s.phase == sps_pkg::SPS_XFER))
    else $error("busy bit does not follow transfer phase");

  chk_multimaster_error_flag_set: assert property ( // [RQ2]
    CFG.master_mode && CFG.ss_input_enable && s.phase == sps_pkg::SPS_XFER && !ss_sync_n
    |=> s.multimaster_error_flag)
    else $error("multimaster error not flagged");

  chk_multimaster_error_flag_sticky: assert property ( // [RQ3]
    s.multimaster_error_flag && !wr_status |=> s.multimaster_error_flag)
    else $error("multimaster error dropped without a write");

  chk_ovf_set: assert property ( // [RQ4]
    seq_unread_tim1 |=> s.receive_overflow_flag)
    else $error("overflow not flagged");

  chk_ovw_replace: assert property ( // [RQ5]
    seq_unread_tim1 ##0 CFG.overflow_overwrite_enable |=> s.rx_data == $past(rx_word))
    else $error("overwrite did not replace receive data");

  chk_keep_old: assert property ( // [RQ6]
    seq_unread_tim1 ##0 !CFG.overflow_overwrite_enable |=> $stable(s.rx_data))
    else $error("receive data changed without overwrite");

  chk_read_clears: assert property ( // [RQ7]
    rd_rx && !byte_done |=> !s.receive_overflow_flag && !s.receive_interrupt_flag
                            && !s.receive_buffer_full_flag && SFR_RDATA == $past(s.rx_data))
    else $error("receive read did not clear flags");

  chk_rxirq_new: assert property ( // [RQ8]
    seq_byte_lands ##0 CFG.transfer_interrupt_mode |=> s.receive_interrupt_flag
                                                       && s.receive_buffer_full_flag)
    else $error("receive flags not set on new byte");

  chk_irq_mode0: assert property ( // [RQ9]
    CFG.port_irq_enable && !CFG.transfer_interrupt_mode && $rose(s.receive_interrupt_flag)
    |-> PORT_IRQ)
    else $error("interrupt not raised");

  chk_halt_select: assert property ( // [RQ10]
    seq_byte_lands ##0 rx_unread && !CFG.transfer_interrupt_mode
    |=> s.phase == sps_pkg::SPS_HALT && SS_N_OUT ##1 SS_N_OUT)
    else $error("transfer not halted on unread data");

  chk_txuf_set: assert property ( // [RQ12]
    seq_byte_lands ##0 !s.tx_full && !wr_tx && (!rx_unread || CFG.transfer_interrupt_mode)
    |=> s.transmit_underflow_flag)
    else $error("transmit underflow not flagged");

  // Flag clears sit before flag sets in the next-state logic, so a set in the same cycle wins.
  chk_multimaster_error_flag_clear: assert property ( // [RQ3]
    wr_status && !SFR_REQ.wdata[`SPS_BIT_MULTIMASTER_ERROR_FLAG] && !(CFG.master_mode && CFG.ss_input_enable
    && s.phase == sps_pkg::SPS_XFER && !ss_sync_n) |=> !s.multimaster_error_flag)
    else $error("multimaster error not cleared by write");

  chk_busy_idle: assert property ( // [RQ1]
    rd_status && s.phase != sps_pkg::SPS_XFER |=> !SFR_RDATA[`SPS_BIT_BUSY])
    else $error("busy bit set while idle");

  chk_rx_loaded: assert property ( // [RQ8]
    seq_byte_lands ##0 !rx_unread
    |=> s.rx_data == $past(rx_word) && s.receive_interrupt_flag)
    else $error("new byte not loaded into receive data");

  chk_rxfull_set: assert property ( // [RQ11]
    seq_byte_lands ##0 (!rx_unread || CFG.transfer_interrupt_mode)
    |=> s.receive_buffer_full_flag)
    else $error("receive buffer full not flagged");

  chk_txuf_clear: assert property ( // [RQ12]
    wr_tx |=> !s.transmit_underflow_flag)
    else $error("transmit underflow not cleared by write");

  chk_irq_off: assert property ( // [RQ9]
    !CFG.port_irq_enable || CFG.transfer_interrupt_mode |=> !PORT_IRQ)
    else $error("interrupt raised while not enabled");

  chk_halt_hold: assert property ( // [RQ10]
    s.phase == sps_pkg::SPS_HALT && s.rx_new && !rd_rx
    |=> s.phase == sps_pkg::SPS_HALT && SS_N_OUT)
    else $error("halt released before receive read");

endmodule

`default_nettype wire

// ==== dv/sps_partner.sv ====
// Behavioural far-side SPI device that exchanges one byte per call.
`timescale 1ns/1ps
`default_nettype none

module sps_partner (
  output logic sclk,
  output logic ser_to_dut,
  input wire logic ser_from_dut
);
  // ==================================================================
  // Idle levels
  // The link clock stands low between frames; it only runs inside a frame.
  initial
  begin
    sclk = 1'b0;
    ser_to_dut = 1'b0;
  end

  // ==================================================================
  // Byte frame, 15 ns link clock, MSB first
  task automatic frame(input logic [7:0] send, output logic [7:0] got);
    for (int i = 7; i >= 0; i--)
    begin
      ser_to_dut = send[i];
      #7.5;
      got = {got[6:0], ser_from_dut};
      sclk = 1'b1;
      #7.5;
      sclk = 1'b0;
    end
    // The released line shows the inverse, so a stale bit never passes for data.
    ser_to_dut = ~ser_to_dut;
  endtask
endmodule

`default_nettype wire

// ==== dv/test_spi_status_flags.sv ====
// Self-checking bench for the SPI status block.
`include "sps_consts.svh"
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module test_spi_status_flags;
  // ==================================================================
  // Signals
  logic clk = 1'b0;
  logic resetn;
  sps_pkg::sps_sfr_s sfr_req;
  logic [7:0] sfr_rdata;
  sps_pkg::sps_cfg_s cfg;
  logic sclk;
  logic ser_in;
  logic ser_out;
  logic ser_oe;
  logic ss_pin;
  logic ss_n_out;
  logic ss_n_oe;
  logic ss_pull_low;
  logic port_irq;
  logic [7:0] far_seen;
  int n_errors = 0;
  int checked = 0;

  always #12.5 clk = ~clk;

  // The select line has a pull-up; another master may pull it low.
  assign ss_pin = ss_n_oe ? ss_n_out : !ss_pull_low;

  sps_top sps_top_inst (
    .CLK(clk),
    .RESETN(resetn),
    .SCLK(sclk),
    .SFR_REQ(sfr_req),
    .SFR_RDATA(sfr_rdata),
    .CFG(cfg),
    .SER_IN(ser_in),
    .SER_OUT(ser_out),
    .SER_OE(ser_oe),
    .SS_N_IN(ss_pin),
    .SS_N_OUT(ss_n_out),
    .SS_N_OE(ss_n_oe),
    .PORT_IRQ(port_irq)
  );

  sps_partner sps_partner_inst (
    .sclk(sclk),
    .ser_to_dut(ser_in),
    .ser_from_dut(ser_out)
  );

  // ==================================================================
  // Register access tasks
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk);
    sfr_req.wr = 1'b0;
  endtask

  task automatic expect_rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    sfr_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk);
    sfr_req.rd = 1'b0;
    @(negedge clk);
    `CHK(sfr_rdata, e)
  endtask

  task automatic wait_ss(input logic lvl);
    int n;
    n = 0;
    while (ss_n_out !== lvl && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(ss_n_out, lvl)
  endtask

  // One master byte: the far side answers with far and must see tx.
  task automatic xfer(input logic [7:0] tx, input logic [7:0] far, input logic peek);
    logic [7:0] seen;
    sfr_wr(`SPS_ADDR_TXDATA, tx);
    wait_ss(1'b0);
    if (peek)
      expect_rd(`SPS_ADDR_STATUS, 8'h80);
    sps_partner_inst.frame(far, seen);
    `CHK(seen, tx)
    wait_ss(1'b1);
    repeat (6) @(negedge clk);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==================================================================
  // Watchdog
  // Generous against the few hundred cycles the tests need.
  initial
  begin
    #1_000_000;
    n_errors++;
    complete_run();
  end

  // ==================================================================
  // Tests
  initial
  begin
    resetn = 1'b0;
    sfr_req = '0;
    ss_pull_low = 1'b0;
    // Mode one is the supported setting for normal operation.
    cfg = '{master_mode: 1'b1, ss_input_enable: 1'b0, transfer_interrupt_mode: 1'b1,
            overflow_overwrite_enable: 1'b0, port_irq_enable: 1'b1};
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    expect_rd(`SPS_ADDR_STATUS, 8'h00);
    expect_rd(8'h10, 8'h00);
    // Plain byte, busy seen while selected.
    xfer(8'ha5, 8'h3c, 1'b1);
    expect_rd(`SPS_ADDR_STATUS, 8'h1c);
    `CHK(port_irq, 1'b0)
    sfr_wr(`SPS_ADDR_STATUS, 8'hff);
    sfr_wr(`SPS_ADDR_RXDATA, 8'hff);
    expect_rd(`SPS_ADDR_RXDATA, 8'h3c);
    expect_rd(`SPS_ADDR_STATUS, 8'h04);
    // Overflow keeping the old byte.
    xfer(8'h11, 8'h5a, 1'b0);
    xfer(8'h22, 8'hc3, 1'b0);
    expect_rd(`SPS_ADDR_STATUS, 8'h3c);
    expect_rd(`SPS_ADDR_RXDATA, 8'h5a);
    expect_rd(`SPS_ADDR_STATUS, 8'h04);
    // Overflow with overwrite.
    cfg.overflow_overwrite_enable = 1'b1;
    xfer(8'h33, 8'h69, 1'b0);
    xfer(8'h44, 8'h96, 1'b0);
    expect_rd(`SPS_ADDR_STATUS, 8'h3c);
    expect_rd(`SPS_ADDR_RXDATA, 8'h96);
    // Mode zero: interrupt, then halt on an unread byte.
    cfg.transfer_interrupt_mode = 1'b0;
    xfer(8'h55, 8'h81, 1'b0);
    `CHK(port_irq, 1'b1)
    xfer(8'h66, 8'h7e, 1'b0);
    repeat (10) @(negedge clk);
    `CHK(ss_n_out, 1'b1)
    expect_rd(`SPS_ADDR_RXDATA, 8'h81);
    repeat (3) @(negedge clk);
    `CHK(port_irq, 1'b0)
    // Another master pulls select low mid-transfer; the byte still completes.
    cfg.transfer_interrupt_mode = 1'b1;
    cfg.ss_input_enable = 1'b1;
    repeat (10) @(negedge clk);
    `CHK(ss_n_oe, 1'b0)
    sfr_wr(`SPS_ADDR_TXDATA, 8'h77);
    wait_ss(1'b0);
    ss_pull_low = 1'b1;
    repeat (6) @(negedge clk);
    ss_pull_low = 1'b0;
    repeat (4) @(negedge clk);
    sps_partner_inst.frame(8'hd2, far_seen);
    `CHK(far_seen, 8'h77)
    wait_ss(1'b1);
    repeat (4) @(negedge clk);
    sfr_wr(`SPS_ADDR_STATUS, 8'h40);
    expect_rd(`SPS_ADDR_STATUS, 8'h5c);
    `CHK(sfr_rdata[`SPS_BIT_MULTIMASTER_ERROR_FLAG], 1'b1)
    sfr_wr(`SPS_ADDR_STATUS, 8'h00);
    repeat (2) @(negedge clk);
    expect_rd(`SPS_ADDR_STATUS, 8'h1c);
    `CHK(sfr_rdata[`SPS_BIT_MULTIMASTER_ERROR_FLAG], 1'b0)
    expect_rd(`SPS_ADDR_RXDATA, 8'hd2);
    // Slave byte: the far side selects us and the old outgoing word is sent again.
    cfg.master_mode = 1'b0;
    cfg.ss_input_enable = 1'b0;
    repeat (4) @(negedge clk);
    ss_pull_low = 1'b1;
    repeat (4) @(negedge clk);
    expect_rd(`SPS_ADDR_STATUS, 8'h84);
    `CHK(ser_oe, 1'b1)
    sps_partner_inst.frame(8'he1, far_seen);
    `CHK(far_seen, 8'h77)
    repeat (6) @(negedge clk);
    expect_rd(`SPS_ADDR_STATUS, 8'h9c);
    ss_pull_low = 1'b0;
    repeat (6) @(negedge clk);
    `CHK(ser_oe, 1'b0)
    expect_rd(`SPS_ADDR_STATUS, 8'h1c);
    expect_rd(`SPS_ADDR_RXDATA, 8'he1);
    complete_run();
  end
endmodule

`default_nettype wire
